// file: dv/fwlg_flash_model.sv
// Behavioural flash array that answers the guard's array strobes.
`timescale 1ns/10ps
module fwlg_flash_model #(
  parameter logic [7:0] LOCK_VAL = 8'hFD
) (
  input wire logic mclk, // System clock.
  input wire logic flash_rd, // Array read strobe.
  input wire logic flash_wr, // Array byte write strobe.
  input wire logic flash_erase, // Array page erase strobe.
  input wire logic [12:0] flash_addr, // Array address.
  input wire logic [7:0] flash_wdata, // Array write data.
  output logic [7:0] flash_rdata // Read data, valid while the read strobe is high.
);
  logic [7:0] mem [0:7679];

  // The array starts erased with the lock byte in its top cell.
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hFF;
    mem[7679] = LOCK_VAL;
  end

  // Read data stands while the strobe does, so the guard takes it at the edge
  // that ends the read cycle; outside a read the bus shows the inverse.
  assign flash_rdata = flash_rd ? mem[flash_addr] : ~mem[flash_addr];

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------
  // store and erase
  always @(posedge mclk)
  begin
    if (flash_wr)
      mem[flash_addr] <= flash_wdata;
    if (flash_erase)
      for (int i = 0; i < 512; i++)
        mem[int'(flash_addr & 13'h1E00) + i] <= 8'hFF;
  end
endmodule : fwlg_flash_model

// file: dv/tb_fwlg_guard.sv
// Self-checking bench for the flash write lock guard.
`timescale 1ns/10ps
module tb_fwlg_guard;
  logic mclk, rst_n, we, ee, pr, xwr, xrd, crd, drd, dwr, der;
  logic [12:0] ca, da, fa, xa;
  logic [7:0] cd, dd, frd, fwd, lock;
  logic frs, fws, fes, xrs, blk, rdy;
  logic [23:0] q [$];
  logic [23:0] seen, exp;
  logic [12:0] r_addr;
  logic [7:0] r_data;
  int bad_count, n_tests, cyc;
  logic [12:0] la [6] = '{13'h0000, 13'h03FF, 13'h0400, 13'h1BFF, 13'h1C00, 13'h1DFF};
  logic lk [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  fwlg_guard fwlg_guard_i (.mclk(mclk), .rst_n(rst_n), .program_store_write_enable(we),
    .program_store_erase_enable(ee), .code_protected(pr), .xdata_wr(xwr), .xdata_rd(xrd),
    .code_rd(crd), .core_addr(ca), .core_wdata(cd), .dbg_rd(drd), .dbg_wr(dwr),
    .dbg_erase(der), .dbg_addr(da), .dbg_wdata(dd), .flash_rdata(frd), .flash_rd(frs),
    .flash_wr(fws), .flash_erase(fes), .flash_addr(fa), .flash_wdata(fwd), .external_data_ram_rd(xrs),
    .external_data_ram_addr(xa), .blocked(blk), .ready(rdy), .lock_reg_out(lock));
  fwlg_flash_model fwlg_flash_model_i (.mclk(mclk), .flash_rd(frs), .flash_wr(fws),
    .flash_erase(fes), .flash_addr(fa), .flash_wdata(fwd), .flash_rdata(frd));

  // Free-running 125 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : check

  // One request; the note is queued before the answer can appear.
  // Source 1 data write, 2 data read, 3 code read, 4-6 debug read, write, erase.
  task automatic op(input int src, input logic [12:0] a, input logic [7:0] d,
                    input logic [2:0] en, input logic [2:0] ek);
    @(posedge mclk);
    {we, ee, pr} <= en;
    ca <= a;
    da <= a;
    cd <= d;
    dd <= d;
    {xwr, xrd, crd, drd, dwr, der} <= 6'h20 >> (src - 1);
    if (ek != 3'h0)
      q.push_back({ek, (ek == 3'h5) ? 13'h0000 : a, (ek == 3'h1) ? d : 8'h00});
    @(posedge mclk);
    {xwr, xrd, crd, drd, dwr, der} <= 6'h00;
  endtask : op

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Any output pulse takes the oldest note; a pulse with none is a fault.
  always @(negedge mclk)
  begin
    if (rst_n === 1'b1 && (frs | fws | fes | xrs | blk) === 1'b1)
    begin
      exp = (q.size() > 0) ? q.pop_front() : 24'hFFFFFF;
      seen[23:21] = fws ? 3'h1 : fes ? 3'h2 : frs ? 3'h3 : xrs ? 3'h4 : 3'h5;
      seen[20:8] = xrs ? xa : blk ? 13'h0000 : fa;
      seen[7:0] = fws ? fwd : 8'h00;
      check("strobe", seen, exp);
    end
  end

  // Hang guard, far above the roughly ninety cycles the tests need.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, we, ee, pr, xwr, xrd, crd, drd, dwr, der} = 10'h000;
    {ca, da, cd, dd} = 42'h0;
    void'($urandom(32'h6a63ef9a));
    repeat (6) @(posedge mclk);
    q.push_back({3'h3, 13'h1DFF, 8'h00});
    rst_n <= 1'b1;
    for (int i = 0; i < 10 && rdy !== 1'b1; i++)
      @(posedge mclk);
    check("ready", {23'h000000, rdy}, 24'h000001);
    check("lock", {16'h0000, lock}, 24'h0000FD);
    $display("test reset done");
    r_addr = 13'h0400 + 13'($urandom % 6144);
    r_data = 8'($urandom);
    op(1, r_addr, r_data, 3'h0, 3'h0);
    op(1, r_addr, r_data, 3'h2, 3'h0);
    op(1, r_addr, r_data, 3'h4, 3'h1);
    op(1, r_addr, r_data, 3'h6, 3'h2);
    $display("test enables done");
    for (int i = 0; i < 6; i++)
    begin
      op(1, la[i], 8'hA5, 3'h4, lk[i] ? 3'h5 : 3'h1);
      op(3, la[i], 8'h00, 3'h4, lk[i] ? 3'h5 : 3'h3);
      op(5, la[i], 8'h3C, 3'h4, lk[i] ? 3'h5 : 3'h1);
    end
    $display("test lock pages done");
    op(1, 13'h0000, 8'h77, 3'h5, 3'h1);
    op(3, 13'h0000, 8'h00, 3'h1, 3'h3);
    op(6, 13'h0000, 8'h00, 3'h1, 3'h5);
    op(6, 13'h0800, 8'h00, 3'h0, 3'h2);
    op(4, 13'h0A00, 8'h00, 3'h0, 3'h3);
    op(4, 13'h0200, 8'h00, 3'h0, 3'h5);
    op(2, 13'h0000, 8'h00, 3'h4, 3'h4);
    op(2, 13'h1DFF, 8'h00, 3'h6, 3'h4);
    $display("test protected and data reads done");
    repeat (8)
      op(1, 13'h0400 + 13'($urandom % 6144), 8'($urandom), 3'h4, 3'h1);
    repeat (4) @(posedge mclk);
    check("drain", 24'(q.size()), 24'h000000);
    $display("test random writes done");
    results();
  end
endmodule : tb_fwlg_guard

// file: logic/fwlg_guard.sv
// Top of the flash write lock guard between core, debug port and array.
`timescale 1ns/10ps
module fwlg_guard #(
  parameter int ADDR_W = fwlg_pkg::ADDR_W,
  parameter logic [12:0] FLASH_BYTES = fwlg_pkg::FLASH_BYTES
) (
  input wire logic mclk, // System clock, 125 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic program_store_write_enable, // Software write enable bit.
  input wire logic program_store_erase_enable, // Software erase enable bit.
  input wire logic code_protected, // Requester runs from a locked page.
  input wire logic xdata_wr, // Data-space write strobe from the core.
  input wire logic xdata_rd, // Data-space read strobe from the core.
  input wire logic code_rd, // Code-space read strobe from the core.
  input wire logic [ADDR_W-1:0] core_addr, // Core address.
  input wire logic [7:0] core_wdata, // Core write data.
  input wire logic dbg_rd, // Debug read strobe.
  input wire logic dbg_wr, // Debug write strobe.
  input wire logic dbg_erase, // Debug page erase strobe.
  input wire logic [ADDR_W-1:0] dbg_addr, // Debug address.
  input wire logic [7:0] dbg_wdata, // Debug write data.
  input wire logic [7:0] flash_rdata, // Array read data, valid while flash_rd is high.
  output logic flash_rd, // Array read strobe.
  output logic flash_wr, // Array byte write strobe.
  output logic flash_erase, // Array page erase strobe.
  output logic [ADDR_W-1:0] flash_addr, // Array address.
  output logic [7:0] flash_wdata, // Array write data.
  output logic external_data_ram_rd, // External data RAM read strobe.
  output logic [ADDR_W-1:0] external_data_ram_addr, // External data RAM address.
  output logic blocked, // Pulse when an access to a locked page was refused.
  output logic ready, // High once the lock byte is loaded.
  output logic [7:0] lock_reg_out // Lock byte in force.
);

  fwlg_pkg::fwlg_state_type state_reg, state_next;
  logic [7:0] lock_reg, lock_next;
  logic frd_reg, frd_next, fwr_reg, fwr_next, fer_reg, fer_next;
  logic xrd_reg, xrd_next, blk_reg, blk_next;
  logic rdy_reg, rdy_next;
  logic [ADDR_W-1:0] fa_reg, fa_next, xa_reg, xa_next;
  logic [7:0] fd_reg, fd_next;
  logic core_lk, dbg_lk, core_wr_is_erase;

  // ----------------------------------------------------------------
  // Lock decisions
  // ----------------------------------------------------------------
  // Two checkers so the core and debug paths are judged in the same cycle.
  fwlg_page_check #(.ADDR_W(ADDR_W), .FLASH_BYTES(FLASH_BYTES)) u_core_chk (
    .lock_byte(lock_reg),
    .addr(core_addr),
    .locked(core_lk)
  );
  fwlg_page_check #(.ADDR_W(ADDR_W), .FLASH_BYTES(FLASH_BYTES)) u_dbg_chk (
    .lock_byte(lock_reg),
    .addr(dbg_addr),
    .locked(dbg_lk)
  );

  // With erase enable also set, a data-space write erases the page.
  assign core_wr_is_erase = program_store_erase_enable;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Core has priority over debug; one array operation per cycle.
  always_comb
  begin
    state_next = state_reg;
    lock_next = lock_reg;
    frd_next = 1'b0;
    fwr_next = 1'b0;
    fer_next = 1'b0;
    xrd_next = 1'b0;
    blk_next = 1'b0;
    rdy_next = rdy_reg;
    fa_next = fa_reg;
    xa_next = xa_reg;
    fd_next = fd_reg;
    unique case (state_reg)
      fwlg_pkg::FWLG_FETCH:
      begin
        frd_next = 1'b1;
        fa_next = ADDR_W'(FLASH_BYTES - 13'h0001);
        state_next = fwlg_pkg::FWLG_WAIT;
      end
      fwlg_pkg::FWLG_WAIT:
      begin
        lock_next = flash_rdata;
        rdy_next = 1'b1;
        state_next = fwlg_pkg::FWLG_RUN;
      end
      fwlg_pkg::FWLG_RUN:
      begin
        if (xdata_rd)
        begin
          xrd_next = 1'b1;
          xa_next = core_addr;
        end
        if (xdata_wr)
        begin
          if (!program_store_write_enable)
          begin
            blk_next = 1'b0;
          end
          else if (core_lk && !code_protected)
          begin
            blk_next = 1'b1;
          end
          else
          begin
            fwr_next = !core_wr_is_erase;
            fer_next = core_wr_is_erase;
            fa_next = core_addr;
            fd_next = core_wdata;
          end
        end
        else if (code_rd)
        begin
          if (core_lk && !code_protected)
          begin
            blk_next = 1'b1;
          end
          else
          begin
            frd_next = 1'b1;
            fa_next = core_addr;
          end
        end
        else if (dbg_rd || dbg_wr || dbg_erase)
        begin
          if (dbg_lk)
          begin
            blk_next = 1'b1;
          end
          else
          begin
            frd_next = dbg_rd;
            fwr_next = dbg_wr && !dbg_rd;
            fer_next = dbg_erase && !dbg_rd && !dbg_wr;
            fa_next = dbg_addr;
            fd_next = dbg_wdata;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Lock resets to all ones only until the fetch completes.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= fwlg_pkg::FWLG_FETCH;
      lock_reg <= fwlg_pkg::LOCK_ERASED;
      frd_reg <= 1'b0;
      fwr_reg <= 1'b0;
      fer_reg <= 1'b0;
      xrd_reg <= 1'b0;
      blk_reg <= 1'b0;
      rdy_reg <= 1'b0;
      fa_reg <= '0;
      xa_reg <= '0;
      fd_reg <= fwlg_pkg::DATA_RESET;
    end
    else
    begin
      state_reg <= state_next;
      lock_reg <= lock_next;
      frd_reg <= frd_next;
      fwr_reg <= fwr_next;
      fer_reg <= fer_next;
      xrd_reg <= xrd_next;
      blk_reg <= blk_next;
      rdy_reg <= rdy_next;
      fa_reg <= fa_next;
      xa_reg <= xa_next;
      fd_reg <= fd_next;
    end
  end

  // Outputs come straight from the registers.
  assign flash_rd = frd_reg;
  assign flash_wr = fwr_reg;
  assign flash_erase = fer_reg;
  assign flash_addr = fa_reg;
  assign flash_wdata = fd_reg;
  assign external_data_ram_rd = xrd_reg;
  assign external_data_ram_addr = xa_reg;
  assign blocked = blk_reg;
  assign ready = rdy_reg;
  assign lock_reg_out = lock_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ram_read;
    xdata_rd && ready;
  endsequence

  AST_RD_RAM: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ram_read |=> external_data_ram_rd && (external_data_ram_addr == $past(core_addr)))
    else $error("data read not sent to RAM");
  AST_NO_WE: assert property (@(posedge mclk) disable iff (!rst_n)
    (xdata_wr && !program_store_write_enable) |=> !flash_wr && !flash_erase)
    else $error("write without enable");
  AST_ERASE: assert property (@(posedge mclk) disable iff (!rst_n)
    flash_erase |-> $past(dbg_erase) || ($past(program_store_write_enable)
      && $past(program_store_erase_enable)))
    else $error("erase without both enables");
  AST_DBG: assert property (@(posedge mclk) disable iff (!rst_n)
    (ready && dbg_rd && !xdata_wr && !code_rd && dbg_lk) |=> blocked && !flash_rd)
    else $error("debug reached locked page");
  AST_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    (ready && xdata_wr && program_store_write_enable && !program_store_erase_enable
     && !core_lk) |=> flash_wr && (flash_wdata == $past(core_wdata)))
    else $error("enabled write lost");
  AST_CODE: assert property (@(posedge mclk) disable iff (!rst_n)
    (ready && code_rd && !xdata_wr && !core_lk) |=> flash_rd)
    else $error("code read lost");
  AST_BLK: assert property (@(posedge mclk) disable iff (!rst_n)
    blocked |-> !flash_wr && !flash_erase && !flash_rd)
    else $error("blocked access reached flash");
  AST_BOOT: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ready) |-> lock_reg == $past(flash_rdata))
    else $error("lock not loaded before run");
  AST_PAGE0: assert property (@(posedge mclk) disable iff (!rst_n)
    (lock_reg != fwlg_pkg::LOCK_ERASED && core_addr == '0) |-> core_lk)
    else $error("page zero not locked");
  AST_LKPG: assert property (@(posedge mclk) disable iff (!rst_n)
    (lock_reg == fwlg_pkg::LOCK_ERASED) |-> !core_lk)
    else $error("erased lock still locks");

endmodule : fwlg_guard

// file: logic/fwlg_page_check.sv
// Page lock decision for one flash address.
`timescale 1ns/10ps
module fwlg_page_check #(
  parameter int ADDR_W = fwlg_pkg::ADDR_W,
  parameter logic [12:0] FLASH_BYTES = fwlg_pkg::FLASH_BYTES
) (
  input wire logic [7:0] lock_byte, // Lock byte value in force.
  input wire logic [ADDR_W-1:0] addr, // Address to classify.
  output logic locked // High when the address sits in a locked page.
);

  logic [7:0] page_count;
  logic [7:0] page_index;
  logic [7:0] lock_page;

  // ----------------------------------------------------------------
  // Page classification
  // ----------------------------------------------------------------
  // Pages below the count are locked, and the lock byte page too unless the byte is erased.
  always_comb
  begin
    page_count = ~lock_byte;
    page_index = 8'(addr >> fwlg_pkg::PAGE_SHIFT);
    lock_page = 8'((FLASH_BYTES - 13'h0001) >> fwlg_pkg::PAGE_SHIFT);
    locked = (page_index < page_count) ||
             ((page_index == lock_page) && (lock_byte != fwlg_pkg::LOCK_ERASED));
  end

endmodule : fwlg_page_check

// file: logic/fwlg_pkg.sv
// Package of constants for the flash write lock guard.
// Notes on behaviour
// - Data writes store flash; code reads return flash.
// - Data-space reads always go to external RAM.
// - Writes ignored unless write enable is set; debug writes go ahead without it.
// - Erase needs both write and erase enables; debug erase needs neither.
// - Last user byte is lock; guards protected pages.
// - Locked page count is complement of lock byte.
// - Lock byte page locked when any bit zero.
package fwlg_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_SHIFT = 9;
  localparam logic [12:0] FLASH_BYTES = 13'h1E00;
  localparam logic [7:0] LOCK_ERASED = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Sequencer states for the lock byte fetch after reset.
  typedef enum logic [1:0] {FWLG_FETCH, FWLG_WAIT, FWLG_RUN} fwlg_state_type;

endpackage : fwlg_pkg
